// ---- branch_unit_consts.vh ----
// Constants for the conditional branch and skip unit.
// Assumes inclusion by bare name from the design file; definitions only.
//
// Function
// - A skip on a set I/O register bit advances the program counter by 2 or 3 words.
// - Branch-on-flag-set adds k plus 1 to the counter when the selected status bit is one.
// - Branch-on-flag-clear adds k plus 1 to the counter when the selected status bit is zero.
// - Branch-if-equal is taken, adding k plus 1, only when the zero flag is one.
// - Branch-if-not-equal is taken, adding k plus 1, only when the zero flag is zero.
// - Branch-if-carry-set is taken, adding k plus 1, only when the carry flag is one.
// - Branch-if-same-or-higher is taken, adding k plus 1, only when the carry flag is zero.
// - Branch-if-lower is taken, adding k plus 1, only when the carry flag is one.
// - Branch-if-minus is taken, adding k plus 1, only when the negative flag is one.
`ifndef BRANCH_UNIT_CONSTS_VH
`define BRANCH_UNIT_CONSTS_VH

// ****************************************************************
// Operation codes
// ****************************************************************
`define OP_WIDTH 4
`define OP_SKIP_IO_SET 4'h0
`define OP_BRANCH_FLAG_SET 4'h1
`define OP_BRANCH_FLAG_CLEAR 4'h2
`define OP_BRANCH_EQUAL 4'h3
`define OP_BRANCH_NOT_EQUAL 4'h4
`define OP_BRANCH_CARRY_SET 4'h5
`define OP_BRANCH_CARRY_CLEAR 4'h6
`define OP_BRANCH_SAME_HIGHER 4'h7
`define OP_BRANCH_LOWER 4'h8
`define OP_BRANCH_MINUS 4'h9

// ****************************************************************
// Status register bit positions
// ****************************************************************
`define FLAG_CARRY 0
`define FLAG_ZERO 1
`define FLAG_NEGATIVE 2

// ****************************************************************
// Step sizes and timing
// ****************************************************************
`define SKIP_SHORT 2
`define SKIP_LONG 3
`define BRANCH_EXTRA 1
`define TAKEN_CYCLES 2

`endif

// ---- conditional_branch_unit.v ----
// Conditional branch and skip decision with program counter update.
// Flags are copied out unchanged; a taken decision loads the counter one cycle later.
// Assumes decoded operands arrive with a one-cycle start strobe and that
// flags and the I/O bit are stable while the start strobe is high.
// Assumes offsets are two's complement and no wider than the counter.
`timescale 1ns/10ps
`include "branch_unit_consts.vh"

module conditional_branch_unit #(
    parameter PC_WIDTH = 16,
    parameter K_WIDTH = 7
) (
    // Clock and reset
    input wire clock,
    input wire rst_n,
    input wire clock_enable,
    // Instruction
    input wire start,
    input wire [`OP_WIDTH-1:0] opcode,
    input wire [2:0] flag_select,
    input wire [K_WIDTH-1:0] offset_k,
    input wire io_bit,
    input wire next_is_long,
    input wire [7:0] status_register,
    // Result
    output wire busy,
    output reg done_reg,
    output reg taken_reg,
    output reg [PC_WIDTH-1:0] pc_reg,
    output reg [7:0] status_out_reg
);

    // ****************************************************************
    // Reset synchroniser
    // ****************************************************************
    reg rst_meta_reg;
    reg rst_sync_reg;
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta_reg <= 1'b0;
            rst_sync_reg <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_sync_reg <= rst_meta_reg;
        end
    end

    // ****************************************************************
    // Sequencer states
    // ****************************************************************
    localparam ST_IDLE = 2'b01;
    localparam ST_RELOAD = 2'b10;

    reg [1:0] state_reg;
    reg [1:0] state_next;

    // ****************************************************************
    // Status bit selection
    // ****************************************************************
    wire [7:0] flag_hit;
    wire sel_bit;

    // One selector cell per status bit; at most one cell fires at a time
    genvar bit_idx;
    generate
        for (bit_idx = 0; bit_idx < 8; bit_idx = bit_idx + 1) begin : g_flag_hit
            assign flag_hit[bit_idx] = (flag_select == bit_idx) & status_register[bit_idx];
        end
    endgenerate
    assign sel_bit = |flag_hit;

    // ****************************************************************
    // Opcode decode
    // ****************************************************************
    wire op_skip_io = (opcode == `OP_SKIP_IO_SET);
    wire op_flag_set = (opcode == `OP_BRANCH_FLAG_SET);
    wire op_flag_clear = (opcode == `OP_BRANCH_FLAG_CLEAR);
    wire op_equal = (opcode == `OP_BRANCH_EQUAL);
    wire op_not_equal = (opcode == `OP_BRANCH_NOT_EQUAL);
    wire op_carry_set = (opcode == `OP_BRANCH_CARRY_SET);
    wire op_carry_clear = (opcode == `OP_BRANCH_CARRY_CLEAR);
    wire op_same_higher = (opcode == `OP_BRANCH_SAME_HIGHER);
    wire op_lower = (opcode == `OP_BRANCH_LOWER);
    wire op_minus = (opcode == `OP_BRANCH_MINUS);

    // Named views of the flags that the fixed branches test
    wire flag_zero = status_register[`FLAG_ZERO];
    wire flag_carry = status_register[`FLAG_CARRY];
    wire flag_negative = status_register[`FLAG_NEGATIVE];

    // ****************************************************************
    // Taken decision
    // ****************************************************************
    // Unknown opcodes match no term, so they are never taken
    wire cond_skip = op_skip_io & io_bit;
    wire cond_flag_set = op_flag_set & sel_bit;
    wire cond_flag_clear = op_flag_clear & ~sel_bit;
    wire cond_equal = op_equal & flag_zero;
    wire cond_not_equal = op_not_equal & ~flag_zero;
    wire cond_carry_set = op_carry_set & flag_carry;
    // Carry-clear and same-or-higher share one test
    wire cond_carry_clear = op_carry_clear & ~flag_carry;
    wire cond_same_higher = op_same_higher & ~flag_carry;
    wire cond_lower = op_lower & flag_carry;
    wire cond_minus = op_minus & flag_negative;

    wire cond;
    wire is_skip;
    assign is_skip = op_skip_io;
    assign cond = cond_skip
        | cond_flag_set
        | cond_flag_clear
        | cond_equal
        | cond_not_equal
        | cond_carry_set
        | cond_carry_clear
        | cond_same_higher
        | cond_lower
        | cond_minus;

    // ****************************************************************
    // Program counter steps
    // ****************************************************************
    // Integer copies are cut to the counter width on purpose
    localparam integer SKIP_SHORT_INT = `SKIP_SHORT;
    localparam integer SKIP_LONG_INT = `SKIP_LONG;
    localparam integer BRANCH_EXTRA_INT = `BRANCH_EXTRA;
    localparam integer PLAIN_STEP_INT = 1;

    wire [PC_WIDTH-1:0] step_short = SKIP_SHORT_INT[PC_WIDTH-1:0];
    wire [PC_WIDTH-1:0] step_long = SKIP_LONG_INT[PC_WIDTH-1:0];
    wire [PC_WIDTH-1:0] branch_one = BRANCH_EXTRA_INT[PC_WIDTH-1:0];
    wire [PC_WIDTH-1:0] step_plain = PLAIN_STEP_INT[PC_WIDTH-1:0];

    // Offset is sign-extended; the counter wraps like a real program counter
    wire [PC_WIDTH-1:0] k_ext = {{(PC_WIDTH-K_WIDTH){offset_k[K_WIDTH-1]}}, offset_k};
    wire [PC_WIDTH-1:0] skip_step = next_is_long ? step_long : step_short;
    wire [PC_WIDTH-1:0] step_taken = is_skip ? skip_step : k_ext + branch_one;

    // ****************************************************************
    // Target adders
    // ****************************************************************
    reg [PC_WIDTH-1:0] target_reg;
    wire [PC_WIDTH-1:0] target_sum = pc_reg + step_taken;
    wire [PC_WIDTH-1:0] pc_plus_one = pc_reg + step_plain;

    // Start is refused while reloading; the busy output says so
    assign busy = (state_reg == ST_RELOAD);

    // ****************************************************************
    // Next-state logic: a taken decision spends a second cycle reloading
    // ****************************************************************
    reg [PC_WIDTH-1:0] target_next;
    reg [PC_WIDTH-1:0] pc_next;
    reg [7:0] status_out_next;
    reg done_next;
    reg taken_next;

    always @* begin
        state_next = state_reg;
        pc_next = pc_reg;
        target_next = target_reg;
        status_out_next = status_out_reg;
        done_next = 1'b0;
        taken_next = taken_reg;
        case (state_reg)
            ST_IDLE: begin
                if (start) begin
                    // Flags pass through untouched in every case
                    status_out_next = status_register;
                    if (cond) begin
                        target_next = target_sum;
                        state_next = ST_RELOAD;
                    end else begin
                        pc_next = pc_plus_one;
                        taken_next = 1'b0;
                        done_next = 1'b1;
                    end
                end
            end
            ST_RELOAD: begin
                pc_next = target_reg;
                taken_next = 1'b1;
                done_next = 1'b1;
                state_next = ST_IDLE;
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    // ****************************************************************
    // Sequencer registers
    // ****************************************************************
    always @(posedge clock or negedge rst_sync_reg) begin
        if (!rst_sync_reg) begin
            state_reg <= ST_IDLE;
            done_reg <= 1'b0;
            taken_reg <= 1'b0;
        end else if (clock_enable) begin
            state_reg <= state_next;
            done_reg <= done_next;
            taken_reg <= taken_next;
        end
    end

    // ****************************************************************
    // Datapath registers; a low clock enable freezes them with the sequencer
    // ****************************************************************
    always @(posedge clock or negedge rst_sync_reg) begin
        if (!rst_sync_reg) begin
            pc_reg <= {PC_WIDTH{1'b0}};
            target_reg <= {PC_WIDTH{1'b0}};
            status_out_reg <= 8'h00;
        end else if (clock_enable) begin
            pc_reg <= pc_next;
            target_reg <= target_next;
            status_out_reg <= status_out_next;
        end
    end

endmodule

// ---- branch_checker_properties.sv ----
// Checker for the branch unit ports.
// Assumes a bind to conditional_branch_unit; the counter width follows its parameter.
`timescale 1ns/10ps
module branch_checker #(
    parameter PC_WIDTH = 16
) (
    // Inputs
    input wire clock,
    input wire rst_n,
    input wire clock_enable,
    input wire start,
    input wire [3:0] opcode,
    input wire [2:0] flag_select,
    input wire [7:0] status_register,
    input wire io_bit,
    // Results
    input wire busy,
    input wire done_reg,
    input wire taken_reg,
    input wire [PC_WIDTH-1:0] pc_reg,
    input wire [7:0] status_out_reg
);
    wire go = start && clock_enable && !busy;
    wire [PC_WIDTH-1:0] pc_one = {{(PC_WIDTH-1){1'b0}}, 1'b1};
    reg go_q, sel_q, io_q;
    reg [7:0] sr_q;
    reg [PC_WIDTH-1:0] pc_q;
    // Inputs as seen at the accepting edge
    always @(posedge clock) begin
        go_q <= go;
        io_q <= io_bit;
        sel_q <= status_register[flag_select];
        sr_q <= status_register;
        pc_q <= pc_reg;
    end
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    flag_set_a: assert property (go && opcode == 4'h1 |=> busy == sel_q) else $error("fs");
    flag_clear_a: assert property (go && opcode == 4'h2
        |=> busy != sel_q) else $error("fc");
    skip_a: assert property (go && opcode == 4'h0
        |=> busy == io_q) else $error("skip");
    equal_a: assert property (go && opcode == 4'h3 |=> busy == sr_q[1]) else $error("eq");
    not_equal_a: assert property (go && opcode == 4'h4 |=> busy != sr_q[1]) else $error("ne");
    carry_a: assert property (go && (opcode == 4'h5 || opcode == 4'h8)
        |=> busy == sr_q[0]) else $error("cs");
    no_carry_a: assert property (go && (opcode == 4'h6 || opcode == 4'h7)
        |=> busy != sr_q[0]) else $error("cc");
    minus_a: assert property (go && opcode == 4'h9 |=> busy == sr_q[2]) else $error("mi");
    reload_done_a: assert property (busy && clock_enable
        |=> done_reg && taken_reg && !busy) else $error("two cycles");
    fall_through_a: assert property (go_q && !busy
        |-> done_reg && !taken_reg && pc_reg == pc_q + pc_one
        && status_out_reg == sr_q) else $error("one");
    cover property (go && opcode == 4'h0);
    cover property (busy);
    cover property (go_q && !busy);
    cover property (busy && !clock_enable);
endmodule

bind conditional_branch_unit branch_checker #(.PC_WIDTH(PC_WIDTH)) u_checker (.clock(clock),
    .rst_n(rst_n), .clock_enable(clock_enable), .start(start), .opcode(opcode),
    .flag_select(flag_select), .status_register(status_register), .io_bit(io_bit),
    .busy(busy), .done_reg(done_reg),
    .taken_reg(taken_reg), .pc_reg(pc_reg), .status_out_reg(status_out_reg));

// ---- test_conditional_branch_unit.sv ----
// Self-checking bench for the branch unit.
// Assumes the design and checker files are compiled with it.
`timescale 1ns/10ps
module test_conditional_branch_unit;
    reg clock = 0, rst_n = 0, start = 0, io_bit = 0, next_is_long = 0, clock_enable = 1;
    reg [3:0] opcode = 0;
    reg [2:0] flag_select = 0;
    reg [6:0] offset_k = 0;
    reg [7:0] status_register = 0;
    reg [7:0] pat = 8'hA5;
    wire busy, done_reg, taken_reg;
    wire [15:0] pc_reg;
    wire [7:0] status_out_reg;
    integer miscompares = 0, n_checks = 0;
    always #2 clock = !clock;
    conditional_branch_unit u_dut (.clock(clock), .rst_n(rst_n), .clock_enable(clock_enable),
        .start(start), .opcode(opcode), .flag_select(flag_select), .offset_k(offset_k),
        .io_bit(io_bit), .next_is_long(next_is_long), .status_register(status_register),
        .busy(busy), .done_reg(done_reg), .taken_reg(taken_reg), .pc_reg(pc_reg),
        .status_out_reg(status_out_reg));
    task check(input [15:0] got, input [15:0] exp);
        begin
            n_checks++;
            if (got !== exp) begin
                miscompares++;
                $display("BAD %0t got %h exp %h", $time, got, exp);
            end
        end
    endtask
    // Taken work needs one extra cycle, so the wait depends on the expectation
    task run(input [3:0] op, input [7:0] sr, input tk, input [15:0] step);
        reg [15:0] pc0;
        begin
            // A quiet edge between strobes, so start never falls and rises in one step
            @(negedge clock);
            pc0 = pc_reg;
            opcode = op;
            status_register = sr;
            start = 1;
            @(negedge clock);
            start = 0;
            if (tk) @(negedge clock);
            check(done_reg, 1);
            check(taken_reg, tk);
            check(pc_reg, pc0 + (tk ? step : 16'h1));
            check(status_out_reg, sr);
        end
    endtask
    task skip_cases;
        begin
            io_bit = 1;
            run(4'h0, 8'h00, 1, 16'h2);
            next_is_long = 1;
            run(4'h0, 8'hFF, 1, 16'h3);
            io_bit = 0;
            run(4'h0, 8'h00, 0, 16'h3);
        end
    endtask
    // Most negative offset
    task flag_cases;
        integer i;
        begin
            offset_k = 7'h40;
            for (i = 0; i < 8; i++) begin
                flag_select = i[2:0];
                run(4'h1, pat, pat[i], 16'hFFC1);
                run(4'h2, pat, !pat[i], 16'hFFC1);
            end
        end
    endtask
    // One flag at a time, so a wrong flag shows; opcodes above 9 never branch
    task named_cases;
        integer i, j;
        reg [7:0] sr;
        reg tk;
        begin
            offset_k = 7'h3F;
            for (i = 3; i < 16; i++) begin
                for (j = 0; j < 4; j++) begin
                    sr = 8'h01 << j;
                    case (i)
                        3: tk = sr[1];
                        4: tk = !sr[1];
                        5, 8: tk = sr[0];
                        6, 7: tk = !sr[0];
                        9: tk = sr[2];
                        default: tk = 0;
                    endcase
                    run(i[3:0], sr, tk, 16'h40);
                end
            end
        end
    endtask
    // Enable low in the reload cycle must hold busy, done_reg and pc_reg until it returns
    task freeze_case;
        reg [15:0] pc0;
        begin
            @(negedge clock);
            pc0 = pc_reg;
            opcode = 4'h3;
            status_register = 8'h02;
            start = 1;
            @(negedge clock);
            start = 0;
            clock_enable = 0;
            repeat (3) @(negedge clock);
            check(busy, 1);
            check(done_reg, 0);
            check(pc_reg, pc0);
            clock_enable = 1;
            @(negedge clock);
            check(done_reg, 1);
            check(taken_reg, 1);
            check(pc_reg, pc0 + 16'h40);
        end
    endtask
    task wrap_up;
        begin
            $display("checks %0d mismatches %0d", n_checks, miscompares);
            if (miscompares == 0 && n_checks > 0)
                $display("All tests passed");
            else
                $display("Some tests failed");
            $finish;
        end
    endtask
    initial begin
        repeat (20) @(negedge clock);
        rst_n = 1;
        repeat (3) @(negedge clock);
        skip_cases;
        flag_cases;
        named_cases;
        freeze_case;
        wrap_up;
    end
endmodule
